// File: logic/cch_pkg.sv
// Shared constants for the calibration command handler ends
package cch_pkg;

    // ------------------------------------------------------------------
    // Frame identifiers
    // ------------------------------------------------------------------
    localparam logic [7:0] ID_PERSIST       = 8'h09;
    localparam logic [7:0] ID_PERSIST_DONE  = 8'h10;
    localparam logic [7:0] ID_BEGIN_CAL     = 8'h0a;
    localparam logic [7:0] ID_ABORT_CAL     = 8'h0b;
    localparam logic [7:0] ID_POINT_COUNT   = 8'h11;
    localparam logic [7:0] ID_SCORE         = 8'h12;
    localparam logic [7:0] ID_REST_MAG      = 8'h1d;
    localparam logic [7:0] ID_REST_MAG_DONE = 8'h1e;
    localparam logic [7:0] ID_TAKE_POINT    = 8'h1f;
    localparam logic [7:0] ID_REST_ACC      = 8'h24;
    localparam logic [7:0] ID_REST_ACC_DONE = 8'h25;
    localparam logic [7:0] ID_MEASUREMENT   = 8'h05;

    // ------------------------------------------------------------------
    // Measurement components and calibration method codes
    // ------------------------------------------------------------------
    localparam logic [31:0] COMP_COUNT     = 32'h0000_0003;
    localparam logic [31:0] COMP_HEADING   = 32'h0000_0005;
    localparam logic [31:0] COMP_PITCH     = 32'h0000_0018;
    localparam logic [31:0] COMP_ROLL      = 32'h0000_0019;
    localparam logic [7:0]  CAL_FULL       = 8'h0a;
    localparam logic [7:0]  CAL_2D         = 8'h14;
    localparam logic [7:0]  CAL_HARD_IRON  = 8'h1e;
    localparam logic [7:0]  CAL_LIMITED    = 8'h28;
    localparam logic [7:0]  CAL_ACCEL      = 8'h64;
    localparam logic [7:0]  CAL_MAG_ACCEL  = 8'h6e;
    localparam logic [7:0]  CAL_RESET      = 8'h0a;

    // ------------------------------------------------------------------
    // Frame sizes, counts and reset values
    // ------------------------------------------------------------------
    localparam logic [2:0]  OPTION_BYTES   = 3'h4;
    localparam logic [15:0] BEGIN_BYTE_CNT = 16'h0009;
    localparam int          FRAME_WORDS    = 7;
    localparam logic [2:0]  LEN_MEAS       = 3'h7;
    localparam logic [2:0]  LEN_SCORE      = 3'h6;
    localparam logic [2:0]  LEN_ONE        = 3'h1;
    localparam logic [2:0]  LEN_NONE       = 3'h0;
    localparam logic [5:0]  MAX_POINTS     = 6'h20;
    localparam logic [15:0] PITCH_MIN_INIT = 16'h7fff;
    localparam logic [15:0] PITCH_MAX_INIT = 16'h8000;
    localparam int          IMG_W          = 10;

    // ------------------------------------------------------------------
    // Host register map (APB byte addresses)
    // ------------------------------------------------------------------
    localparam logic [7:0] REG_CMD      = 8'h00;
    localparam logic [7:0] REG_OPTION   = 8'h04;
    localparam logic [7:0] REG_STATUS   = 8'h08;
    localparam logic [7:0] REG_RSP_DATA = 8'h0c;
    localparam int         CMD_LEN_LSB  = 8;
    localparam int         CMD_AUTO_BIT = 16;

endpackage

// File: logic/cch_link_if.sv
// Frame link between the host end and the sensor end
`timescale 1ns/100ps
interface cch_link_if (
    input wire logic pclk,
    input wire logic presetn
);
    logic        cmd_valid;
    logic        cmd_ready;
    logic [7:0]  cmd_id;
    logic [2:0]  cmd_len;
    logic [31:0] cmd_option;
    logic        rsp_valid;
    logic        rsp_ready;
    logic [7:0]  rsp_id;
    logic [31:0] rsp_word;
    logic        rsp_last;

    modport dev  (input  cmd_valid, cmd_id, cmd_len, cmd_option, rsp_ready,
                  output cmd_ready, rsp_valid, rsp_id, rsp_word, rsp_last);
    modport host (output cmd_valid, cmd_id, cmd_len, cmd_option, rsp_ready,
                  input  cmd_ready, rsp_valid, rsp_id, rsp_word, rsp_last);
endinterface

// File: logic/cch_device.sv
// Sensor end: calibration and settings-persistence command handling
//
// The register offsets and the APB slave port were decided locally.
`timescale 1ns/100ps
module cch_device
    import cch_pkg::*;
(
    input  wire logic                pclk,
    input  wire logic                presetn,
    cch_link_if.dev                  link,
    output logic                     nvm_load_req,
    input  wire logic                nvm_load_done,
    input  wire logic [IMG_W-1:0]    nvm_load_image,
    output logic                     nvm_write_req,
    output logic [IMG_W-1:0]         nvm_write_image,
    input  wire logic                nvm_done,
    input  wire logic                nvm_fail,
    input  wire logic                auto_sampling,
    input  wire logic [5:0]          required_points,
    input  wire logic [5:0]          min_points,
    input  wire logic                stable,
    input  wire logic                min_change,
    input  wire logic                meas_strobe,
    input  wire logic [31:0]         heading_val,
    input  wire logic [31:0]         pitch_val,
    input  wire logic [31:0]         roll_val,
    input  wire logic signed [15:0]  pitch_deg,
    input  wire logic signed [15:0]  roll_deg,
    input  wire logic [31:0]         mag_quality,
    input  wire logic [31:0]         accel_quality,
    input  wire logic [31:0]         spread_error,
    input  wire logic [31:0]         tilt_shortfall,
    output logic                     mag_coeff_user,
    output logic                     accel_coeff_user,
    output logic                     coeff_commit,
    output logic                     cal_active,
    output logic [7:0]               method,
    output logic [5:0]               point_count
);

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {S_LOAD, S_IDLE, S_SAVE, S_SEND} cch_dev_state_e;
    typedef logic [31:0] cch_frame_t [FRAME_WORDS];

    function automatic logic code_known(input logic [7:0] c);
        return c == CAL_FULL || c == CAL_2D || c == CAL_HARD_IRON ||
               c == CAL_LIMITED || c == CAL_ACCEL || c == CAL_MAG_ACCEL;
    endfunction

    function automatic logic uses_mag(input logic [7:0] c);
        return c != CAL_ACCEL;
    endfunction

    function automatic logic uses_accel(input logic [7:0] c);
        return c == CAL_ACCEL || c == CAL_MAG_ACCEL;
    endfunction

    function automatic logic [15:0] half_span(input logic signed [15:0] hi,
                                              input logic signed [15:0] lo);
        logic signed [16:0] d;
        d = 17'(hi) - 17'(lo);
        return d[16:1];
    endfunction

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    cch_dev_state_e     state, next_state;
    cch_frame_t         frame_w, ld_w;
    logic [2:0]         frame_len, ld_len;
    logic [7:0]         frame_id, ld_id;
    logic               ld;
    logic               armed, pending_score;
    logic signed [15:0] pmin, pmax, rmin, rmax;
    logic [15:0]        tilt_span;

    wire logic idle       = state == S_IDLE;
    wire logic cmd_take   = idle && !pending_score && link.cmd_valid;
    wire logic opt_full   = link.cmd_len >= OPTION_BYTES;
    wire logic [7:0] code = link.cmd_option[7:0];
    wire logic is_begin   = cmd_take && link.cmd_id == ID_BEGIN_CAL;
    wire logic is_take    = cmd_take && link.cmd_id == ID_TAKE_POINT;
    wire logic is_abort   = cmd_take && link.cmd_id == ID_ABORT_CAL;
    wire logic is_rmag    = cmd_take && link.cmd_id == ID_REST_MAG;
    wire logic is_racc    = cmd_take && link.cmd_id == ID_REST_ACC;
    wire logic is_persist = cmd_take && link.cmd_id == ID_PERSIST;
    // Upper option bytes are zero for all known codes
    wire logic opt_ok     = opt_full && link.cmd_option[31:8] == 24'h0 &&
                            code_known(code);
    wire logic gate_ok    = point_count == 6'h0 ||
                            (auto_sampling ? min_change : armed);
    wire logic point_ok   = idle && !pending_score && !link.cmd_valid &&
                            cal_active && stable && gate_ok;
    wire logic [5:0] cnt_inc   = point_count + 6'h1;
    wire logic last_point = point_ok &&
                            (cnt_inc == required_points || cnt_inc == MAX_POINTS);
    wire logic abort_calc = is_abort && cal_active &&
                            point_count >= min_points;
    wire logic commit     = last_point || abort_calc;
    wire logic meas_ok    = idle && !pending_score && !link.cmd_valid &&
                            !point_ok && cal_active && meas_strobe;
    wire logic signed [15:0] pmin_n = pitch_deg < pmin ? pitch_deg : pmin;
    wire logic signed [15:0] pmax_n = pitch_deg > pmax ? pitch_deg : pmax;
    wire logic signed [15:0] rmin_n = roll_deg < rmin ? roll_deg : rmin;
    wire logic signed [15:0] rmax_n = roll_deg > rmax ? roll_deg : rmax;
    wire logic [15:0] pspan = half_span(pmax, pmin);
    wire logic [15:0] rspan = half_span(rmax, rmin);

    assign tilt_span = pspan > rspan ? pspan : rspan;

    // ------------------------------------------------------------------
    // Frame selection and sequencing
    // ------------------------------------------------------------------
    always_comb
    begin
        next_state = state;
        ld         = 1'b0;
        ld_id      = 8'h0;
        ld_len     = LEN_NONE;
        ld_w       = '{default: 32'h0};
        unique case (state)
            S_LOAD:
                if (nvm_load_done)
                    next_state = S_IDLE;
            S_IDLE:
            begin
                if (pending_score)
                begin
                    ld     = 1'b1;
                    ld_id  = ID_SCORE;
                    ld_len = LEN_SCORE;
                    ld_w   = '{mag_quality, 32'h0, accel_quality,
                               spread_error, tilt_shortfall,
                               {16'h0, tilt_span}, 32'h0};
                end
                else if (is_persist)
                    next_state = S_SAVE;
                else if (is_begin)
                begin
                    ld     = 1'b1;
                    ld_id  = ID_POINT_COUNT;
                    ld_len = LEN_ONE;
                end
                else if (is_rmag || is_racc)
                begin
                    ld     = 1'b1;
                    ld_id  = is_rmag ? ID_REST_MAG_DONE : ID_REST_ACC_DONE;
                    ld_len = LEN_ONE;
                end
                else if (point_ok)
                begin
                    ld       = 1'b1;
                    ld_id    = ID_POINT_COUNT;
                    ld_len   = LEN_ONE;
                    ld_w[0]  = {26'h0, cnt_inc};
                end
                else if (meas_ok)
                begin
                    ld     = 1'b1;
                    ld_id  = ID_MEASUREMENT;
                    ld_len = LEN_MEAS;
                    ld_w   = '{COMP_COUNT, COMP_HEADING, heading_val,
                               COMP_PITCH, pitch_val, COMP_ROLL, roll_val};
                end
            end
            S_SAVE:
                if (nvm_done)
                begin
                    ld     = 1'b1;
                    ld_id  = ID_PERSIST_DONE;
                    ld_len = LEN_ONE;
                    ld_w[0] = {31'h0, nvm_fail};
                end
            S_SEND:
                if (link.rsp_ready && frame_len == LEN_ONE)
                    next_state = S_IDLE;
        endcase
        if (ld)
            next_state = S_SEND;
    end

    // Restore done frames have no payload: a single beat with a zero word marks them; persist done carries nvm_fail
    assign link.cmd_ready   = cmd_take;
    assign link.rsp_valid   = state == S_SEND;
    assign link.rsp_id      = frame_id;
    assign link.rsp_word    = frame_w[0];
    assign link.rsp_last    = frame_len == LEN_ONE;
    assign nvm_load_req     = state == S_LOAD;
    assign nvm_write_req    = state == S_SAVE;
    assign nvm_write_image  = {mag_coeff_user, accel_coeff_user, method};

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
            state <= S_LOAD;
        else
            state <= next_state;

    always_ff @(posedge pclk)
        if (ld)
        begin
            frame_w   <= ld_w;
            frame_len <= ld_len;
            frame_id  <= ld_id;
        end
        else if (state == S_SEND && link.rsp_ready)
        begin
            frame_w   <= '{frame_w[1], frame_w[2], frame_w[3], frame_w[4],
                           frame_w[5], frame_w[6], 32'h0};
            frame_len <= frame_len - LEN_ONE;
        end

    // Volatile coefficient selection; only the save state exports it
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
        begin
            method           <= CAL_RESET;
            mag_coeff_user   <= 1'b0;
            accel_coeff_user <= 1'b0;
        end
        else if (state == S_LOAD && nvm_load_done)
            {mag_coeff_user, accel_coeff_user, method} <= nvm_load_image;
        else
        begin
            if (is_begin && opt_ok)
                method <= code;
            if (commit && uses_mag(method))
                mag_coeff_user <= 1'b1;
            else if (is_rmag)
                mag_coeff_user <= 1'b0;
            if (commit && uses_accel(method))
                accel_coeff_user <= 1'b1;
            else if (is_racc)
                accel_coeff_user <= 1'b0;
        end

    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
        begin
            cal_active    <= 1'b0;
            point_count   <= 6'h0;
            armed         <= 1'b0;
            pending_score <= 1'b0;
            coeff_commit  <= 1'b0;
        end
        else
        begin
            coeff_commit <= commit;
            if (is_begin)
            begin
                cal_active  <= 1'b1;
                point_count <= 6'h0;
                armed       <= 1'b0;
            end
            else if (point_ok)
            begin
                point_count <= cnt_inc;
                armed       <= 1'b0;
                cal_active  <= !last_point;
            end
            else if (is_abort)
                cal_active <= 1'b0;
            else if (is_take && cal_active)
                armed <= 1'b1;
            if (commit)
                pending_score <= 1'b1;
            else if (ld && idle)
                pending_score <= 1'b0;
        end

    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
        begin
            pmin <= PITCH_MIN_INIT;
            pmax <= PITCH_MAX_INIT;
            rmin <= PITCH_MIN_INIT;
            rmax <= PITCH_MAX_INIT;
        end
        else if (is_begin)
        begin
            pmin <= PITCH_MIN_INIT;
            pmax <= PITCH_MAX_INIT;
            rmin <= PITCH_MIN_INIT;
            rmax <= PITCH_MAX_INIT;
        end
        else if (point_ok)
        begin
            pmin <= pmin_n;
            pmax <= pmax_n;
            rmin <= rmin_n;
            rmax <= rmax_n;
        end

endmodule // cch_device

// File: logic/cch_host.sv
// Host end: APB-controlled sender of calibration command frames
`timescale 1ns/100ps
module cch_host
    import cch_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    cch_link_if.host         link
);

    // ------------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------------
    logic        busy, wait_done, auto_persist, chain;
    logic [7:0]  last_id;
    logic [31:0] option, last_word;

    wire logic wr     = psel && penable && pwrite;
    wire logic wr_cmd = wr && paddr == REG_CMD && !busy;
    wire logic wr_opt = wr && paddr == REG_OPTION;
    wire logic [7:0] new_id = pwdata[7:0];
    wire logic is_rest = new_id == ID_REST_MAG || new_id == ID_REST_ACC;
    wire logic sent    = link.cmd_valid && link.cmd_ready;
    wire logic rsp_fin = link.rsp_valid && link.rsp_last;
    wire logic done_rx = rsp_fin && (link.rsp_id == ID_PERSIST_DONE ||
                         link.rsp_id == ID_REST_MAG_DONE ||
                         link.rsp_id == ID_REST_ACC_DONE);

    assign pready        = 1'b1;
    assign pslverr       = 1'b0;
    assign link.rsp_ready = 1'b1;
    assign prdata = paddr == REG_OPTION   ? option :
                    paddr == REG_STATUS   ? {23'h0, last_id, busy} :
                    paddr == REG_RSP_DATA ? last_word : 32'h0;

    // ------------------------------------------------------------------
    // Command sequencing
    // ------------------------------------------------------------------
    // A new command is refused while the previous one is untaken, or for persist and restore commands unanswered
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
        begin
            link.cmd_valid  <= 1'b0;
            link.cmd_id     <= 8'h0;
            link.cmd_len    <= LEN_NONE;
            link.cmd_option <= 32'h0;
            busy            <= 1'b0;
            wait_done       <= 1'b0;
            chain           <= 1'b0;
            auto_persist    <= 1'b0;
        end
        else if (wr_cmd)
        begin
            link.cmd_valid  <= 1'b1;
            link.cmd_id     <= new_id;
            link.cmd_len    <= pwdata[CMD_LEN_LSB+2:CMD_LEN_LSB];
            link.cmd_option <= option;
            busy            <= 1'b1;
            auto_persist    <= pwdata[CMD_AUTO_BIT] && is_rest;
            wait_done       <= new_id == ID_PERSIST || is_rest;
        end
        else if (sent)
        begin
            link.cmd_valid <= 1'b0;
            busy           <= wait_done;
            chain          <= auto_persist;
            auto_persist   <= 1'b0;
        end
        else if (done_rx && busy && !link.cmd_valid)
        begin
            if (chain)
            begin
                link.cmd_valid <= 1'b1;
                link.cmd_id    <= ID_PERSIST;
                link.cmd_len   <= LEN_NONE;
                chain          <= 1'b0;
            end
            else
                busy <= 1'b0;
        end

    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
        begin
            option    <= 32'h0;
            last_id   <= 8'h0;
            last_word <= 32'h0;
        end
        else
        begin
            if (wr_opt)
                option <= pwdata;
            if (link.rsp_valid)
            begin
                last_id   <= link.rsp_id;
                last_word <= link.rsp_word;
            end
        end

endmodule // cch_host

// File: verification/cch_link_props.sv
// Link checker for the calibration command handler
`timescale 1ns/100ps
module cch_link_props
    import cch_pkg::*;
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        cmd_valid,
    input wire logic        cmd_ready,
    input wire logic [7:0]  cmd_id,
    input wire logic [31:0] cmd_option,
    input wire logic        rsp_valid,
    input wire logic [7:0]  rsp_id,
    input wire logic [31:0] rsp_word,
    input wire logic        rsp_last
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    logic prev_end;
    wire  take  = cmd_valid && cmd_ready;
    wire  first = rsp_valid && prev_end;
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
            prev_end <= 1'b1;
        else
            prev_end <= !rsp_valid || rsp_last;
    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    AST_ONE_AT_A_TIME: assert property (rsp_valid |-> !cmd_ready)
        else $error("Command accepted during a response");
    AST_CMD_HELD: assert property (cmd_valid && !cmd_ready |=>
        cmd_valid && $stable(cmd_id) && $stable(cmd_option))
        else $error("Command changed before it was taken");
    AST_BEGIN_ZERO: assert property (take && cmd_id == ID_BEGIN_CAL |=>
        rsp_valid && rsp_id == ID_POINT_COUNT && rsp_word == 0 && rsp_last)
        else $error("Begin not answered by a zero count");
    AST_MAG_DONE: assert property (take && cmd_id == ID_REST_MAG |=>
        rsp_valid && rsp_id == ID_REST_MAG_DONE && rsp_last)
        else $error("Magnetic restore not answered");
    AST_ACC_DONE: assert property (take && cmd_id == ID_REST_ACC |=>
        rsp_valid && rsp_id == ID_REST_ACC_DONE && rsp_last)
        else $error("Accel restore not answered");
    AST_MEAS_ORDER: assert property (first && rsp_id == ID_MEASUREMENT |->
        rsp_word == COMP_COUNT ##1 rsp_word == COMP_HEADING ##2
        rsp_word == COMP_PITCH ##2 rsp_word == COMP_ROLL ##1 rsp_last)
        else $error("Measurement frame out of order");
    AST_COUNT_RANGE: assert property (rsp_valid && rsp_id == ID_POINT_COUNT
        |-> rsp_last && rsp_word <= 32'h20)
        else $error("Point count frame malformed");
    AST_SCORE_SIX: assert property (first && rsp_id == ID_SCORE |->
        (rsp_valid && rsp_id == ID_SCORE && !rsp_last)[*5] ##1
        (rsp_valid && rsp_last))
        else $error("Score frame not six words");
    AST_PERSIST_CODE: assert property (rsp_valid && rsp_id == ID_PERSIST_DONE
        |-> rsp_last && rsp_word <= 32'h1)
        else $error("Persist done code out of range");
    cover property (take && cmd_id == ID_BEGIN_CAL);
    cover property (first && rsp_id == ID_SCORE);
    cover property (first && rsp_id == ID_MEASUREMENT);
endmodule // cch_link_props

// File: verification/tb_top.sv
// Self-checking bench for both ends of the calibration command link
`timescale 1ns/100ps
module tb_top;
    import cch_pkg::*;
    logic             pclk = 0, presetn = 0, psel = 0, penable = 0;
    logic             pwrite = 0, pready, pslverr, r, cms = 0;
    logic [7:0]       paddr = 0, meth;
    logic [31:0]      pwdata = 0, prdata, q, hv = 32'h11, mq = 32'h1;
    logic             ld_req, ld_done = 0, wr_req, nvm_done = 0;
    logic             nvm_fail = 0, fail_sel = 0, auto_s = 0, stable = 0;
    logic             min_chg = 0, meas = 0, mag_u, acc_u, commit, cal_on;
    logic [IMG_W-1:0] ld_img = 0, wr_img, img_q = 0;
    logic [5:0]       req_pts = 6'h02, min_pts = 6'h01, pts;
    logic signed [15:0] pdeg = 0, rdeg = 0;
    logic [7:0]       codes [6] = '{CAL_FULL, CAL_2D, CAL_HARD_IRON,
                                    CAL_LIMITED, CAL_ACCEL, CAL_MAG_ACCEL};
    int               num_errors = 0, total_checks = 0;
    always #2 pclk = ~pclk;
    // Storage answers each write request with a done pulse
    always @(posedge pclk)
    begin
        nvm_done <= wr_req && !nvm_done;
        nvm_fail <= fail_sel;
        if (wr_req) img_q <= wr_img;
        cms <= cms | commit;
    end
    cch_link_if link (.pclk(pclk), .presetn(presetn));
    cch_host cch_host_i (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link));
    cch_device cch_device_i (.pclk(pclk), .presetn(presetn), .link(link),
        .nvm_load_req(ld_req), .nvm_load_done(ld_done),
        .nvm_load_image(ld_img), .nvm_write_req(wr_req),
        .nvm_write_image(wr_img), .nvm_done(nvm_done), .nvm_fail(nvm_fail),
        .auto_sampling(auto_s), .required_points(req_pts),
        .min_points(min_pts), .stable(stable), .min_change(min_chg),
        .meas_strobe(meas), .heading_val(hv), .pitch_val(32'h22),
        .roll_val(32'h33), .pitch_deg(pdeg), .roll_deg(rdeg),
        .mag_quality(mq), .accel_quality(32'h2), .spread_error(32'h3),
        .tilt_shortfall(32'h4), .mag_coeff_user(mag_u),
        .accel_coeff_user(acc_u), .coeff_commit(commit), .cal_active(cal_on),
        .method(meth), .point_count(pts));
    cch_link_props cch_link_props_i (.pclk(pclk), .presetn(presetn),
        .cmd_valid(link.cmd_valid), .cmd_ready(link.cmd_ready),
        .cmd_id(link.cmd_id), .cmd_option(link.cmd_option),
        .rsp_valid(link.rsp_valid), .rsp_id(link.rsp_id),
        .rsp_word(link.rsp_word), .rsp_last(link.rsp_last));
    task tally_and_finish;
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // A wait that runs out is a mismatch and ends the run
    task bail(input logic ok);
        if (ok !== 1'b1)
        begin
            chk(32'h0, 32'h1);
            tally_and_finish;
        end
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Read data is taken as it stood at the completing edge
        for (int n = 0; n < 20; n++)
        begin
            @(negedge pclk);
            q = prdata;
            r = pready && !pslverr;
            @(posedge pclk);
            if (r) break;
        end
        bail(r);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task cmd(input logic [7:0] id, input logic [8:0] len,
             input logic [31:0] o);
        apb(1'b1, REG_OPTION, o);
        apb(1'b1, REG_CMD, {15'h0, len[8], 5'h0, len[2:0], id});
        for (int n = 0; n < 50; n++)
        begin
            apb(1'b0, REG_STATUS, 32'h0);
            if (q[0] === 1'b0) break;
        end
        bail(q[0] === 1'b0);
    endtask
    task wait_pts(input logic [5:0] n);
        for (int k = 0; k < 200 && pts !== n; k++)
            @(posedge pclk);
        bail(pts === n);
    endtask
    initial
    begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(negedge pclk);
        chk(ld_req, 1'b1);
        @(posedge pclk);
        ld_img <= {2'b11, CAL_2D};
        ld_done <= 1'b1;
        @(posedge pclk);
        ld_done <= 1'b0;
        repeat (2) @(posedge pclk);
        chk({mag_u, meth}, {1'b1, CAL_2D});
        cmd(ID_ABORT_CAL, 3'h0, 32'h0);
        chk({cal_on, mag_u, acc_u}, 3'b011);
        cmd(ID_REST_MAG, 3'h0, 32'h0);
        chk({mag_u, q[8:1]}, {1'b0, ID_REST_MAG_DONE});
        cmd(ID_REST_ACC, 3'h0, 32'h0);
        chk({acc_u, q[8:1], wr_req}, {1'b0, ID_REST_ACC_DONE, 1'b0});
        cmd(ID_REST_MAG, 9'h100, 32'h0);
        chk({img_q, q[8:1]}, {2'b00, CAL_2D, ID_PERSIST_DONE});
        for (int i = 0; i < 2; i++)
        begin
            fail_sel <= ~i[0];
            cmd(ID_PERSIST, 3'h0, 32'h0);
            apb(1'b0, REG_RSP_DATA, 32'h0);
            chk(q, {31'h0, ~i[0]});
            chk(img_q, {2'b00, CAL_2D});
        end
        foreach (codes[i])
        begin
            cmd(ID_BEGIN_CAL, OPTION_BYTES, {24'h0, codes[i]});
            chk(meth, codes[i]);
            apb(1'b0, REG_RSP_DATA, 32'h0);
            chk(q, 32'h0);
            cmd(ID_ABORT_CAL, 3'h0, 32'h0);
            chk({cal_on, mag_u}, 2'b00);
        end
        cmd(ID_BEGIN_CAL, 3'h2, {24'h0, CAL_2D});
        chk(meth, CAL_MAG_ACCEL);
        cmd(ID_ABORT_CAL, 3'h0, 32'h0);
        pdeg <= 16'sd10;
        rdeg <= 16'sd25;
        cmd(ID_BEGIN_CAL, OPTION_BYTES, {24'h0, CAL_FULL});
        meas <= 1'b1;
        @(posedge pclk);
        meas <= 1'b0;
        repeat (10) @(posedge pclk);
        stable <= 1'b1;
        wait_pts(6'h01);
        pdeg <= -16'sd20;
        rdeg <= -16'sd15;
        repeat (10) @(posedge pclk);
        chk(pts, 6'h01);
        cmd(ID_TAKE_POINT, 3'h0, 32'h0);
        wait_pts(6'h02);
        repeat (20) @(posedge pclk);
        stable <= 1'b0;
        apb(1'b0, REG_RSP_DATA, 32'h0);
        chk(q, 32'h14);
        chk({cal_on, wr_req, mag_u, cms}, 4'b0011);
        tally_and_finish;
    end
endmodule // tb_top
